// ===== gpio_fsel_pkg.sv
// Notes on behaviour
// - Eight ports A..H of eight pins; 15 to 58 usable depending on peripherals.
// - An output pin may change level every two clock cycles.
// - Per-pin event sensing: rising, falling or both edges, or high/low level.
// - Each pin's interrupt is individually masked by software.
// - Address bits act as a per-bit mask on data reads and writes.
// - A pin event can start a converter sample sequence.
// - Alternate function routed only with alt-select, digital enable and matching code.
// - Digital enable clear connects the converter input through its isolation path.
// - Digital enable clear connects the comparator input directly.
// - Function selection is per pin; no grouping of pins.
// - Reset leaves pins undriven GPIO, all config zero, except listed pins.
// - Power-on reset and external reset both restore the default configuration.
// - PA[5:0], PB[3:2] reset to code 0x1; PC[3:0] to code 0x3 with pull-up.
package gpio_fsel_pkg;

	localparam int             NUM_PORTS     = 8;
	localparam int             PINS_PER_PORT = 8;
	localparam int             NUM_PINS      = NUM_PORTS * PINS_PER_PORT;
	localparam int             CODE_W        = 4;
	localparam int             PIN_IDX_W     = 6;
	localparam int             PORT_IDX_W    = 3;
	localparam int             TOGGLE_CYCLES = 2;

	localparam logic [CODE_W-1:0] CODE_SERIAL = 4'h1;
	localparam logic [CODE_W-1:0] CODE_DEBUG  = 4'h3;

	// Pin n sits at bit n = port*8 + bit; PA0-5, PB2-3 and PC0-3 leave reset as functions
	localparam logic [63:0] SERIAL_PINS = 64'h0000_0000_0000_0c3f;
	localparam logic [63:0] DEBUG_PINS  = 64'h0000_0000_000f_0000;
	localparam logic [63:0] AFSEL_RST   = SERIAL_PINS | DEBUG_PINS;
	localparam logic [63:0] DEN_RST     = SERIAL_PINS | DEBUG_PINS;
	localparam logic [63:0] PUR_RST     = DEBUG_PINS;
	localparam logic [63:0] PDR_RST     = 64'h0000_0000_0000_0000;
	localparam logic [63:0] DATA_RST    = 64'h0000_0000_0000_0000;
	localparam logic [63:0] DIR_RST     = 64'h0000_0000_0000_0000;

	function automatic logic [NUM_PINS*CODE_W-1:0] code_reset();
		logic [NUM_PINS*CODE_W-1:0] v;
		v = '0;
		for (int n = 0; n < NUM_PINS; n++)
		begin
			if (SERIAL_PINS[n])
				v[n*CODE_W +: CODE_W] = CODE_SERIAL;
			else if (DEBUG_PINS[n])
				v[n*CODE_W +: CODE_W] = CODE_DEBUG;
		end
		return v;
	endfunction : code_reset

	localparam logic [NUM_PINS*CODE_W-1:0] PCTL_RST = code_reset();

	function automatic logic [NUM_PINS-1:0] port_spread(input logic [PORT_IDX_W-1:0] port,
		input logic [PINS_PER_PORT-1:0] bits);
		logic [NUM_PINS-1:0] v;
		v = '0;
		v[port*PINS_PER_PORT +: PINS_PER_PORT] = bits;
		return v;
	endfunction : port_spread

endpackage : gpio_fsel_pkg

// ===== gpio_event_detect.sv
`timescale 1ns/1ps
`default_nettype none
module gpio_event_detect #(
	parameter int W = 8
) (
	input  wire logic         clk_i,
	input  wire logic         nrst_i,
	input  wire logic         srst_i,
	input  wire logic [W-1:0] din_i,
	input  wire logic [W-1:0] level_mode_i,
	input  wire logic [W-1:0] both_edges_i,
	input  wire logic [W-1:0] high_rise_i,
	input  wire logic [W-1:0] int_mask_i,
	input  wire logic [W-1:0] clear_i,
	output logic      [W-1:0] event_o,
	output logic      [W-1:0] raw_o,
	output logic              int_o
);

	logic [W-1:0] prev_q, prev_d;
	logic [W-1:0] raw_q,  raw_d;
	logic [W-1:0] rise, fall, edge_hit, level_hit;

	always_comb
	begin
		rise      = din_i & ~prev_q;
		fall      = ~din_i & prev_q;
		edge_hit  = (both_edges_i & (rise | fall))
			| (~both_edges_i & ((high_rise_i & rise) | (~high_rise_i & fall)));
		level_hit = (high_rise_i & din_i) | (~high_rise_i & ~din_i);
		prev_d    = din_i;
		// Level status follows the pin; edge status is sticky and a new edge beats the clear
		raw_d     = (level_mode_i & level_hit)
			| (~level_mode_i & (edge_hit | (raw_q & ~clear_i)));
		event_o   = (level_mode_i & level_hit) | (~level_mode_i & edge_hit);
	end

	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			prev_q <= '0;
			raw_q  <= '0;
		end
		else if (srst_i)
		begin
			prev_q <= '0;
			raw_q  <= '0;
		end
		else
		begin
			prev_q <= prev_d;
			raw_q  <= raw_d;
		end
	end

	assign raw_o = raw_q;
	assign int_o = |(raw_q & int_mask_i);

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!nrst_i || srst_i);

	a_edge_sticky: assert property (((|(edge_hit & ~level_mode_i)) && $stable(level_mode_i))
		|=> (raw_q & $past(edge_hit & ~level_mode_i)) == $past(edge_hit & ~level_mode_i))
		else $error("edge event not latched");
	a_int_gate: assert property (int_o |-> (|(raw_q & int_mask_i)) && (|raw_q))
		else $error("interrupt raised with no unmasked status");
	c_edge_int: cover property (!int_o ##1 int_o);

endmodule : gpio_event_detect
`default_nettype wire

// ===== gpio_pin_function_select.sv
`timescale 1ns/1ps
`default_nettype none
module gpio_pin_function_select #(
	parameter int NUM_PINS = gpio_fsel_pkg::NUM_PINS,
	parameter logic [NUM_PINS*gpio_fsel_pkg::CODE_W-1:0] ALT_CODE = gpio_fsel_pkg::PCTL_RST,
	parameter logic [NUM_PINS-1:0] ADC_PINS = '0,
	parameter logic [NUM_PINS-1:0] CMP_PINS = '0
) (
	input  wire logic                                 CLOCK_I,
	input  wire logic                                 NRST_I,
	input  wire logic                                 EXT_RST_N_I,
	input  wire logic                                 CFG_WE_I,
	input  wire logic [gpio_fsel_pkg::PIN_IDX_W-1:0]  CFG_PIN_I,
	input  wire logic                                 CFG_ALT_SEL_I,
	input  wire logic                                 CFG_DIG_EN_I,
	input  wire logic                                 CFG_PULL_UP_I,
	input  wire logic                                 CFG_PULL_DOWN_I,
	input  wire logic [gpio_fsel_pkg::CODE_W-1:0]     CFG_FUNC_CODE_I,
	input  wire logic                                 CFG_DIR_OUT_I,
	input  wire logic                                 CFG_LEVEL_MODE_I,
	input  wire logic                                 CFG_BOTH_EDGES_I,
	input  wire logic                                 CFG_HIGH_RISE_I,
	input  wire logic                                 CFG_INT_MASK_I,
	input  wire logic                                 CFG_ADC_TRIG_EN_I,
	input  wire logic                                 DATA_WE_I,
	input  wire logic [gpio_fsel_pkg::PORT_IDX_W-1:0] DATA_PORT_I,
	input  wire logic [7:0]                           DATA_ADDR_MASK_I,
	input  wire logic [7:0]                           DATA_WDATA_I,
	output logic      [7:0]                           DATA_RDATA_O,
	input  wire logic                                 INT_CLR_I,
	input  wire logic [gpio_fsel_pkg::PORT_IDX_W-1:0] INT_CLR_PORT_I,
	input  wire logic [7:0]                           INT_CLR_MASK_I,
	output logic      [gpio_fsel_pkg::NUM_PORTS-1:0]  PORT_INT_O,
	output logic      [NUM_PINS-1:0]                  RAW_STATUS_O,
	output logic                                      ADC_TRIG_O,
	input  wire logic [NUM_PINS-1:0]                  PIN_IN_I,
	output logic      [NUM_PINS-1:0]                  PIN_OUT_O,
	output logic      [NUM_PINS-1:0]                  PIN_OE_O,
	output logic      [NUM_PINS-1:0]                  PIN_PULL_UP_O,
	output logic      [NUM_PINS-1:0]                  PIN_PULL_DOWN_O,
	input  wire logic [NUM_PINS-1:0]                  ALT_OUT_I,
	input  wire logic [NUM_PINS-1:0]                  ALT_OE_I,
	output logic      [NUM_PINS-1:0]                  ALT_IN_O,
	output logic      [NUM_PINS-1:0]                  ALT_ACTIVE_O,
	output logic      [NUM_PINS-1:0]                  ADC_ISO_EN_O,
	output logic      [NUM_PINS-1:0]                  CMP_CONN_O
);

	localparam int CW = gpio_fsel_pkg::CODE_W;
	localparam int PP = gpio_fsel_pkg::PINS_PER_PORT;
	localparam int TOGGLE = gpio_fsel_pkg::TOGGLE_CYCLES;

	////////////////////////////////////////////////////////////////////////////////////
	// Synchronisers for pins and the external reset pin

	logic [NUM_PINS-1:0] pin_s1_q, pin_s2_q;
	logic                rst_s1_q, rst_s2_q;
	logic                ext_rst;

	always_ff @(posedge CLOCK_I or negedge NRST_I)
	begin
		if (!NRST_I)
		begin
			pin_s1_q <= '0;
			pin_s2_q <= '0;
			rst_s1_q <= 1'b0;
			rst_s2_q <= 1'b0;
		end
		else
		begin
			pin_s1_q <= PIN_IN_I;
			pin_s2_q <= pin_s1_q;
			rst_s1_q <= EXT_RST_N_I;
			rst_s2_q <= rst_s1_q;
		end
	end

	// Held for as long as the reset pin is low, and for two cycles after power-on release
	assign ext_rst = !rst_s2_q;

	////////////////////////////////////////////////////////////////////////////////////
	// Per-pin configuration: one pin written per access, no shared fields

	logic [NUM_PINS-1:0]    afsel_q, afsel_d, den_q, den_d, pur_q, pur_d, pdr_q, pdr_d;
	logic [NUM_PINS-1:0]    dir_q, dir_d, lvl_q, lvl_d, both_q, both_d, hr_q, hr_d;
	logic [NUM_PINS-1:0]    im_q, im_d, atrig_q, atrig_d;
	logic [NUM_PINS*CW-1:0] pctl_q, pctl_d;
	logic [NUM_PINS-1:0]    sel;

	always_comb
	begin
		sel     = '0;
		sel[CFG_PIN_I] = CFG_WE_I;
		afsel_d = (afsel_q & ~sel) | (sel & {NUM_PINS{CFG_ALT_SEL_I}});
		den_d   = (den_q & ~sel) | (sel & {NUM_PINS{CFG_DIG_EN_I}});
		pur_d   = (pur_q & ~sel) | (sel & {NUM_PINS{CFG_PULL_UP_I}});
		pdr_d   = (pdr_q & ~sel) | (sel & {NUM_PINS{CFG_PULL_DOWN_I}});
		dir_d   = (dir_q & ~sel) | (sel & {NUM_PINS{CFG_DIR_OUT_I}});
		lvl_d   = (lvl_q & ~sel) | (sel & {NUM_PINS{CFG_LEVEL_MODE_I}});
		both_d  = (both_q & ~sel) | (sel & {NUM_PINS{CFG_BOTH_EDGES_I}});
		hr_d    = (hr_q & ~sel) | (sel & {NUM_PINS{CFG_HIGH_RISE_I}});
		im_d    = (im_q & ~sel) | (sel & {NUM_PINS{CFG_INT_MASK_I}});
		atrig_d = (atrig_q & ~sel) | (sel & {NUM_PINS{CFG_ADC_TRIG_EN_I}});
		pctl_d  = pctl_q;
		if (CFG_WE_I)
			pctl_d[CFG_PIN_I*CW +: CW] = CFG_FUNC_CODE_I;
	end

	always_ff @(posedge CLOCK_I or negedge NRST_I)
	begin
		if (!NRST_I)
		begin
			afsel_q <= gpio_fsel_pkg::AFSEL_RST;
			den_q   <= gpio_fsel_pkg::DEN_RST;
			pur_q   <= gpio_fsel_pkg::PUR_RST;
			pdr_q   <= gpio_fsel_pkg::PDR_RST;
			pctl_q  <= gpio_fsel_pkg::PCTL_RST;
			dir_q   <= gpio_fsel_pkg::DIR_RST;
			lvl_q   <= '0;
			both_q  <= '0;
			hr_q    <= '0;
			im_q    <= '0;
			atrig_q <= '0;
		end
		else if (ext_rst)
		begin
			afsel_q <= gpio_fsel_pkg::AFSEL_RST;
			den_q   <= gpio_fsel_pkg::DEN_RST;
			pur_q   <= gpio_fsel_pkg::PUR_RST;
			pdr_q   <= gpio_fsel_pkg::PDR_RST;
			pctl_q  <= gpio_fsel_pkg::PCTL_RST;
			dir_q   <= gpio_fsel_pkg::DIR_RST;
			lvl_q   <= '0;
			both_q  <= '0;
			hr_q    <= '0;
			im_q    <= '0;
			atrig_q <= '0;
		end
		else
		begin
			afsel_q <= afsel_d;
			den_q   <= den_d;
			pur_q   <= pur_d;
			pdr_q   <= pdr_d;
			pctl_q  <= pctl_d;
			dir_q   <= dir_d;
			lvl_q   <= lvl_d;
			both_q  <= both_d;
			hr_q    <= hr_d;
			im_q    <= im_d;
			atrig_q <= atrig_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////////
	// Masked data access; a write lands in one cycle so a pin can toggle every other cycle

	logic [NUM_PINS-1:0] data_q, data_d, wmask, wdata, din;
	logic [7:0]          rdata_q, rdata_d;
	logic [NUM_PINS-1:0] rd_src;

	always_comb
	begin
		wmask   = gpio_fsel_pkg::port_spread(DATA_PORT_I, DATA_WE_I ? DATA_ADDR_MASK_I : 8'h00);
		wdata   = gpio_fsel_pkg::port_spread(DATA_PORT_I, DATA_WDATA_I);
		data_d  = (data_q & ~wmask) | (wdata & wmask);
		din     = pin_s2_q & den_q;
		rd_src  = (dir_q & data_q) | (~dir_q & din);
		rdata_d = rd_src[DATA_PORT_I*PP +: PP] & DATA_ADDR_MASK_I;
	end

	always_ff @(posedge CLOCK_I or negedge NRST_I)
	begin
		if (!NRST_I)
		begin
			data_q  <= gpio_fsel_pkg::DATA_RST;
			rdata_q <= 8'h00;
		end
		else if (ext_rst)
		begin
			data_q  <= gpio_fsel_pkg::DATA_RST;
			rdata_q <= 8'h00;
		end
		else
		begin
			data_q  <= data_d;
			rdata_q <= rdata_d;
		end
	end

	assign DATA_RDATA_O = rdata_q;

	////////////////////////////////////////////////////////////////////////////////////
	// Function routing and analog connection

	logic [NUM_PINS-1:0] alt_act;

	always_comb
	begin
		for (int n = 0; n < NUM_PINS; n++)
			alt_act[n] = afsel_q[n] && den_q[n]
				&& (pctl_q[n*CW +: CW] == ALT_CODE[n*CW +: CW]);
	end

	assign ALT_ACTIVE_O    = alt_act;
	assign PIN_OUT_O       = (alt_act & ALT_OUT_I) | (~alt_act & data_q);
	assign PIN_OE_O        = den_q & ((alt_act & ALT_OE_I) | (~alt_act & ~afsel_q & dir_q));
	assign ALT_IN_O        = alt_act & din;
	assign PIN_PULL_UP_O   = pur_q;
	assign PIN_PULL_DOWN_O = pdr_q;
	assign ADC_ISO_EN_O    = ~den_q & ADC_PINS;
	assign CMP_CONN_O      = ~den_q & CMP_PINS;

	////////////////////////////////////////////////////////////////////////////////////
	// Event sensing, one detector per port

	logic [NUM_PINS-1:0] evt, clr;
	logic                trig_q, trig_d;

	assign clr = gpio_fsel_pkg::port_spread(INT_CLR_PORT_I, INT_CLR_I ? INT_CLR_MASK_I : 8'h00);

	for (genvar p = 0; p < gpio_fsel_pkg::NUM_PORTS; p++)
	begin : g_port
		gpio_event_detect #(.W(PP)) u_det (
			.clk_i        (CLOCK_I),
			.nrst_i       (NRST_I),
			.srst_i       (ext_rst),
			.din_i        (din[p*PP +: PP]),
			.level_mode_i (lvl_q[p*PP +: PP]),
			.both_edges_i (both_q[p*PP +: PP]),
			.high_rise_i  (hr_q[p*PP +: PP]),
			.int_mask_i   (im_q[p*PP +: PP]),
			.clear_i      (clr[p*PP +: PP]),
			.event_o      (evt[p*PP +: PP]),
			.raw_o        (RAW_STATUS_O[p*PP +: PP]),
			.int_o        (PORT_INT_O[p])
		);
	end

	// Registered; an edge event gives the converter a one-cycle start, a level event holds it for as long as the level lasts
	assign trig_d = |(evt & atrig_q);

	always_ff @(posedge CLOCK_I or negedge NRST_I)
	begin
		if (!NRST_I)
			trig_q <= 1'b0;
		else
			trig_q <= trig_d;
	end

	assign ADC_TRIG_O = trig_q;

	////////////////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge CLOCK_I); endclocking
	default disable iff (!NRST_I);

	a_no_drive_off: assert property ((PIN_OE_O & ~den_q) == '0 && (ALT_IN_O & ~den_q) == '0)
		else $error("pin driven or read while digital disabled");
	a_write_lands: assert property (DATA_WE_I && !ext_rst ##1 !ext_rst
		|-> (data_q & $past(wmask)) == ($past(wdata) & $past(wmask)))
		else $error("data write not applied next cycle");
	a_write_masked: assert property (!ext_rst ##1 !ext_rst
		|-> ((data_q ^ $past(data_q)) & ~$past(wmask)) == '0)
		else $error("unmasked data bit changed");
	a_read_masked: assert property (1'b1 |=> (DATA_RDATA_O & ~$past(DATA_ADDR_MASK_I)) == 8'h00)
		else $error("read returned unmasked bit");
	a_ext_restore: assert property (ext_rst |=> afsel_q == gpio_fsel_pkg::AFSEL_RST
		&& den_q == gpio_fsel_pkg::DEN_RST && pctl_q == gpio_fsel_pkg::PCTL_RST
		&& pur_q == gpio_fsel_pkg::PUR_RST && pdr_q == '0)
		else $error("external reset did not restore defaults");
	a_pin_indep: assert property (!ext_rst ##1 !ext_rst
		|-> ((afsel_q ^ $past(afsel_q)) & ~$past(sel)) == '0)
		else $error("unselected pin configuration changed");
	a_alt_route: assert property ((alt_act & (PIN_OUT_O ^ ALT_OUT_I)) == '0
		&& (alt_act & ~(afsel_q & den_q)) == '0)
		else $error("alternate function routed without selection");
	a_analog_conn: assert property (ADC_ISO_EN_O == (~den_q & ADC_PINS)
		&& CMP_CONN_O == (~den_q & CMP_PINS))
		else $error("analog connection does not follow digital enable");
	a_adc_start: assert property ((|(evt & atrig_q)) |=> ADC_TRIG_O)
		else $error("enabled pin event did not start converter");

	c_toggle: cover property (DATA_WE_I ##TOGGLE DATA_WE_I);
	c_adc: cover property (ADC_TRIG_O);
	c_alt: cover property ($rose(|alt_act));
	c_ext_rst: cover property (ext_rst ##1 !ext_rst);

endmodule : gpio_pin_function_select
`default_nettype wire

// ===== gpio_pad_model.sv
`timescale 1ns/1ps
`default_nettype none
module gpio_pad_model (
	input  wire logic        clk_i,
	input  wire logic [63:0] out_i,
	input  wire logic [63:0] oe_i,
	input  wire logic [63:0] pu_i,
	input  wire logic [63:0] pd_i,
	input  wire logic [63:0] drv_en_i,
	input  wire logic [63:0] drv_val_i,
	output logic      [63:0] pin_o
);
	// A floating pad never settles to a clean level, so it wanders every cycle
	logic [63:0] float_q = 64'h5555_5555_5555_5555;

	always_ff @(posedge clk_i)
		float_q <= ~float_q;

	// The device's own drive wins over the outside circuit
	always_comb
		for (int n = 0; n < 64; n++)
			pin_o[n] = oe_i[n] ? out_i[n] : drv_en_i[n] ? drv_val_i[n] :
				pu_i[n] ? 1'b1 : pd_i[n] ? 1'b0 : float_q[n];
endmodule : gpio_pad_model
`default_nettype wire

// ===== gpio_pin_function_select_bench.sv
`timescale 1ns/1ps
`default_nettype none
module gpio_pin_function_select_bench;
	typedef struct {string s; int w; logic [63:0] m; logic [63:0] e;} note_t;
	logic        clock_i = 1'b0, nrst_i = 1'b0, ext_rst_n_i = 1'b1;
	logic        cfg_we = 1'b0, data_we = 1'b0, int_clr = 1'b0;
	logic [5:0]  cfg_pin = 6'h0;
	logic [13:0] cfg_f = 14'h0;
	logic [2:0]  data_port = 3'h0, clr_port = 3'h0;
	logic [7:0]  data_mask = 8'h0, data_wd = 8'h0, clr_mask = 8'h0, exp8, rdata, port_int;
	logic [63:0] alt_out = 64'hc3a5_5a3c_0ff0_9669, alt_oe = '1;
	logic [63:0] drv_en = 64'h0, drv_val = 64'h0, a;
	logic [63:0] raw, pin_in, pin_out, pin_oe, pu, pd, alt_act, adc_iso, cmp_conn, alt_in;
	logic        adc_trig;
	logic [15:0] rs = 16'hdb64;
	logic [3:0]  mt [5] = '{4'h1, 4'h8, 4'ha, 4'h5, 4'hc};
	note_t       notes [$];
	note_t       n;
	event        note_ev;
	int          num_errors = 0, checked = 0;

	always #25 clock_i = ~clock_i;

	gpio_pin_function_select #(.ADC_PINS(64'h1), .CMP_PINS(64'h2)) uut (
		.CLOCK_I(clock_i), .NRST_I(nrst_i), .EXT_RST_N_I(ext_rst_n_i),
		.CFG_WE_I(cfg_we), .CFG_PIN_I(cfg_pin), .CFG_ALT_SEL_I(cfg_f[13]),
		.CFG_DIG_EN_I(cfg_f[12]), .CFG_PULL_UP_I(cfg_f[11]), .CFG_PULL_DOWN_I(cfg_f[10]),
		.CFG_FUNC_CODE_I(cfg_f[9:6]), .CFG_DIR_OUT_I(cfg_f[5]), .CFG_LEVEL_MODE_I(cfg_f[4]),
		.CFG_BOTH_EDGES_I(cfg_f[3]), .CFG_HIGH_RISE_I(cfg_f[2]), .CFG_INT_MASK_I(cfg_f[1]),
		.CFG_ADC_TRIG_EN_I(cfg_f[0]), .DATA_WE_I(data_we), .DATA_PORT_I(data_port),
		.DATA_ADDR_MASK_I(data_mask), .DATA_WDATA_I(data_wd), .DATA_RDATA_O(rdata),
		.INT_CLR_I(int_clr), .INT_CLR_PORT_I(clr_port), .INT_CLR_MASK_I(clr_mask),
		.PORT_INT_O(port_int), .RAW_STATUS_O(raw), .ADC_TRIG_O(adc_trig), .PIN_IN_I(pin_in),
		.PIN_OUT_O(pin_out), .PIN_OE_O(pin_oe), .PIN_PULL_UP_O(pu), .PIN_PULL_DOWN_O(pd),
		.ALT_OUT_I(alt_out), .ALT_OE_I(alt_oe), .ALT_IN_O(alt_in), .ALT_ACTIVE_O(alt_act),
		.ADC_ISO_EN_O(adc_iso), .CMP_CONN_O(cmp_conn)
	);

	gpio_pad_model pads (
		.clk_i(clock_i), .out_i(pin_out), .oe_i(pin_oe), .pu_i(pu), .pd_i(pd),
		.drv_en_i(drv_en), .drv_val_i(drv_val), .pin_o(pin_in)
	);

	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsr

	function automatic logic [63:0] actual(input int w);
		case (w)
			0: return pu;
			1: return pd;
			2: return pin_oe;
			3: return alt_act;
			4: return {56'h0, rdata};
			5: return raw;
			6: return {56'h0, port_int};
			7: return {63'h0, adc_trig};
			8: return adc_iso;
			9: return pin_out;
			10: return cmp_conn;
			default: return alt_in;
		endcase
	endfunction : actual

	task automatic note(input string s, input int w, input logic [63:0] m, input logic [63:0] e);
		notes.push_back('{s, w, m, e});
		->note_ev;
	endtask : note

	always @(note_ev)
		while (notes.size() > 0)
		begin
			n = notes.pop_front();
			a = actual(n.w) & n.m;
			checked++;
			if (a !== n.e)
			begin
				num_errors++;
				$display("mismatch %s expected %h seen %h", n.s, n.e, a);
			end
		end

	task automatic tally_and_finish();
		#1;
		$display("checks %0d mismatches %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : tally_and_finish

	////////////////////////////////////////////////////////////////////////////////
	// Every strobe is dropped on the edge that takes it, then outputs are read mid-cycle
	task automatic cfg(input logic [5:0] p, input logic [13:0] f);
		@(posedge clock_i);
		cfg_we  <= 1'b1;
		cfg_pin <= p;
		cfg_f   <= f;
		@(posedge clock_i);
		cfg_we <= 1'b0;
		@(negedge clock_i);
	endtask : cfg

	task automatic wr(input logic [2:0] p, input logic [7:0] m, input logic [7:0] d);
		@(posedge clock_i);
		data_we   <= 1'b1;
		data_port <= p;
		data_mask <= m;
		data_wd   <= d;
		@(posedge clock_i);
		data_we <= 1'b0;
		@(negedge clock_i);
	endtask : wr

	task automatic rd(input logic [2:0] p, input logic [7:0] m);
		@(posedge clock_i);
		data_port <= p;
		data_mask <= m;
		@(posedge clock_i);
		@(negedge clock_i);
	endtask : rd

	task automatic clr(input logic [2:0] p, input logic [7:0] m);
		@(posedge clock_i);
		int_clr  <= 1'b1;
		clr_port <= p;
		clr_mask <= m;
		@(posedge clock_i);
		int_clr <= 1'b0;
		@(negedge clock_i);
	endtask : clr

	task automatic wait_raw();
		for (int k = 0; k < 10; k++)
		begin
			@(negedge clock_i);
			if (raw[32] === 1'b1)
				return;
		end
		num_errors++;
		$display("mismatch raw status expected 1 seen 0");
		tally_and_finish();
	endtask : wait_raw

	task automatic check_defaults(input string s);
		note("pull up", 0, '1, gpio_fsel_pkg::PUR_RST);
		note("pull down", 1, '1, 64'h0);
		note("drive enable", 2, '1, gpio_fsel_pkg::AFSEL_RST);
		note("routing", 3, '1, gpio_fsel_pkg::AFSEL_RST);
		note("alt drive", 9, gpio_fsel_pkg::AFSEL_RST, alt_out & gpio_fsel_pkg::AFSEL_RST);
		note("alt input", 11, gpio_fsel_pkg::AFSEL_RST, alt_out & gpio_fsel_pkg::AFSEL_RST);
		$display("test %s done", s);
	endtask : check_defaults

	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (8) @(posedge clock_i);
		nrst_i <= 1'b1;
		repeat (3) @(posedge clock_i);
		@(negedge clock_i);
		check_defaults("power-on reset");
		cfg(6'd0, 14'h3080);
		note("route code mismatch", 3, 64'h1, 64'h0);
		note("drive code mismatch", 2, 64'h1, 64'h0);
		cfg(6'd0, 14'h3040);
		note("route code match", 3, '1, gpio_fsel_pkg::AFSEL_RST);
		cfg(6'd0, 14'h2040);
		note("drive without enable", 2, '1, gpio_fsel_pkg::AFSEL_RST & ~64'h1);
		note("isolation path", 8, '1, 64'h1);
		cfg(6'd1, 14'h2040);
		note("comparator path", 10, '1, 64'h2);
		note("route without enable", 3, '1, gpio_fsel_pkg::AFSEL_RST & ~64'h3);
		$display("test routing done");
		for (int p = 24; p < 32; p++)
			cfg(p[5:0], (p == 26) ? 14'h1420 : 14'h1020);
		note("pull down per pin", 1, '1, 64'h0400_0000);
		note("output enable", 2, 64'hff00_0000, 64'hff00_0000);
		exp8 = 8'h0;
		repeat (6)
		begin
			rs = lfsr(rs);
			wr(3'd3, rs[7:0], rs[15:8]);
			exp8 = (exp8 & ~rs[7:0]) | (rs[15:8] & rs[7:0]);
			note("masked write", 9, 64'hff00_0000, {32'h0, exp8, 24'h0});
			rd(3'd3, rs[15:8]);
			note("masked read", 4, '1, {56'h0, exp8 & rs[15:8]});
		end
		for (int k = 0; k < 4; k++)
		begin
			wr(3'd3, 8'h01, {7'h0, ~k[0]});
			note("toggle", 9, 64'h0100_0000, {39'h0, ~k[0], 24'h0});
		end
		$display("test port data done");
		for (int p = 32; p < 40; p++)
			cfg(p[5:0], (p == 39) ? 14'h0 : 14'h1000);
		rs = lfsr(rs);
		@(posedge clock_i);
		drv_en  <= 64'h0000_00ff_0000_0000;
		drv_val <= {24'h0, rs[7:0], 32'h0};
		repeat (4) @(posedge clock_i);
		rd(3'd4, rs[15:8]);
		note("input read", 4, '1, {56'h0, rs[15:8] & rs[7:0] & 8'h7f});
		$display("test input read done");
		// Each mode: start level, then the change that must be seen
		for (int m = 0; m < 5; m++)
		begin
			@(posedge clock_i);
			drv_val[32] <= mt[m][3];
			cfg(6'd32, 14'h1003 | {9'h0, mt[m][2:0], 2'b00});
			repeat (4) @(posedge clock_i);
			clr(3'd4, 8'h01);
			note("quiet status", 5, 64'h1_0000_0000, 64'h0);
			@(posedge clock_i);
			drv_val[32] <= ~mt[m][3];
			wait_raw();
			note("port interrupt", 6, '1, 64'h10);
			note("converter start", 7, '1, 64'h1);
			if (m < 3)
			begin
				clr(3'd4, 8'h01);
				note("cleared status", 5, 64'h1_0000_0000, 64'h0);
				note("start pulse over", 7, '1, 64'h0);
			end
		end
		cfg(6'd32, 14'h1011);
		note("masked interrupt", 6, '1, 64'h0);
		note("level still seen", 5, 64'h1_0000_0000, 64'h1_0000_0000);
		$display("test events done");
		@(posedge clock_i);
		ext_rst_n_i <= 1'b0;
		repeat (4) @(posedge clock_i);
		ext_rst_n_i <= 1'b1;
		repeat (4) @(posedge clock_i);
		@(negedge clock_i);
		check_defaults("external reset");
		tally_and_finish();
	end
endmodule : gpio_pin_function_select_bench
`default_nettype wire
